/* hdl/sbc_synth_control.sv */
/*
  register file, carrier staging, modulation, bit timing, rc trim, clock and pin routing.
  assumes the serial register port decodes into byte reads and writes on clk_sys.
*/
// Functional notes
// - step is reference over two to nineteen
// - carrier is step times 24-bit word
// - carrier applies only on low byte write
// - bit rate from rate word plus fraction
// - on-off keying ignores the rate fraction
// - data pin raw, or synced to bit clock
// - deviation is step times 14-bit word
// - trim request runs calibration, sets done
// - rc trim runs automatically at power-up
// - synthesizer starts once crystal is stable
// - reference clock out on pin five
// - low battery routed to chosen pin other than two
// - receive uses low-consumption synthesizer only
// - bit clock pulses once per needed bit
`timescale 1ns/1ps
`default_nettype none
module sbc_synth_control (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clkEn,
  input wire logic [6:0] regAddr,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  input wire logic txBitValid,
  input wire logic txBitData,
  output logic txBitReady,
  input wire logic txSerialDataPin,
  input wire logic xtalStable,
  input wire logic lowBatteryCross,
  output logic [5:0] generalPinOut,
  output logic [5:0] generalPinOe,
  output sbc_pkg::sbc_synth_type synthConfig,
  output logic txPaOn,
  output logic rcTrimActive,
  output logic extRefSelect,
  output logic [2:0] supplyThreshold
);
  typedef struct packed {
    sbc_pkg::sbc_regs_type regs;
    logic pend;
    logic [23:0] carrier;
    sbc_pkg::sbc_trim_state_type trim;
    logic [9:0] trimCount;
    logic trimDone;
    logic [5:0] clkDiv;
    logic curBit;
    logic bitClk;
    logic [5:0] pinOut;
    logic [5:0] pinOe;
    sbc_pkg::sbc_synth_type synth;
    logic paOn;
    logic [7:0] rdata;
  } sbc_state_type;

  localparam sbc_state_type STATE_RST = '{sbc_pkg::REGS_RST, 1'b0, 24'h00_0000,
    sbc_pkg::TRIM_RUN, 10'h000, 1'b0, 6'h00, 1'b0, 1'b0, 6'h00, 6'h00,
    sbc_pkg::SYNTH_RST, 1'b0, 8'h00};

  sbc_state_type state_q;
  sbc_state_type state_d;
  logic txOn;
  logic sleep;
  logic packetTx;
  logic contGauss;
  logic contRaw;
  logic divTick;
  logic [19:0] period16;
  logic [19:0] rawPeriod;
  logic [13:0] devWord;
  logic [23:0] synthWord;
  logic bufInValid;
  logic bufInData;
  logic bufInReady;
  logic bufOutValid;
  logic bufOutData;
  logic [5:0] batSel;
  logic lowBatLevel;
  logic [2:0] clkField;

  // ----------------------------------------
  // mode decode
  // ----------------------------------------
  assign sleep = state_q.regs.mode[sbc_pkg::MODE_SLEEP_BIT];
  assign txOn = state_q.regs.mode[sbc_pkg::MODE_TX_BIT] && !sleep;
  assign packetTx = txOn && !state_q.regs.mode[sbc_pkg::MODE_CONT_BIT];
  assign contGauss = txOn && state_q.regs.mode[sbc_pkg::MODE_CONT_BIT]
    && state_q.regs.mode[sbc_pkg::MODE_GAUSS_BIT];
  assign contRaw = txOn && state_q.regs.mode[sbc_pkg::MODE_CONT_BIT]
    && !state_q.regs.mode[sbc_pkg::MODE_GAUSS_BIT];
  assign rawPeriod = {state_q.regs.rateHigh, state_q.regs.rateLow,
    state_q.regs.mode[sbc_pkg::MODE_OOK_BIT] ? 4'h0 : state_q.regs.rateFrac};
  // rate words below two cycles would let the bit clock merge into a level
  assign period16 = (rawPeriod < sbc_pkg::MIN_PERIOD16) ? sbc_pkg::MIN_PERIOD16 : rawPeriod;
  assign devWord = {state_q.regs.devHigh, state_q.regs.devLow};
  assign lowBatLevel = lowBatteryCross && state_q.regs.supply[sbc_pkg::SUPPLY_ENABLE_BIT];
  assign batSel = sbc_pkg::sbc_pin_select(state_q.regs.routing[2:0]);
  assign clkField = state_q.regs.routingTwo[2:0];

  // ----------------------------------------
  // bit timing and buffer
  // ----------------------------------------
  sbc_rate_divider rateDivider (
    .clk_sys(clk_sys),
    .reset(reset),
    .clkEn(clkEn),
    .run(packetTx || contGauss),
    .period16(period16),
    .tick(divTick)
  );

  // with filtering the pin is sampled on each bit clock pulse
  assign bufInValid = packetTx ? txBitValid : (contGauss && divTick);
  assign bufInData = packetTx ? txBitData : txSerialDataPin;
  assign txBitReady = packetTx && bufInReady;

  sbc_bit_buffer #(
    .WIDTH(1),
    .DEPTH(2)
  ) bitBuffer (
    .clk_sys(clk_sys),
    .reset(reset),
    .clkEn(clkEn),
    .inValid(bufInValid),
    .inData(bufInData),
    .inReady(bufInReady),
    .outValid(bufOutValid),
    .outData(bufOutData),
    .outReady(divTick && (packetTx || contGauss))
  );

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    state_d = state_q;
    state_d.pend = 1'b0;
    if (regWrite) begin
      case (regAddr)
        sbc_pkg::ADDR_MODE: state_d.regs.mode = regWdata;
        sbc_pkg::ADDR_RATE_HIGH: state_d.regs.rateHigh = regWdata;
        sbc_pkg::ADDR_RATE_LOW: state_d.regs.rateLow = regWdata;
        sbc_pkg::ADDR_RATE_FRAC: state_d.regs.rateFrac = regWdata[3:0];
        sbc_pkg::ADDR_DEV_HIGH: state_d.regs.devHigh = regWdata[5:0];
        sbc_pkg::ADDR_DEV_LOW: state_d.regs.devLow = regWdata;
        sbc_pkg::ADDR_CARRIER_HIGH: state_d.regs.carrierHigh = regWdata;
        sbc_pkg::ADDR_CARRIER_MID: state_d.regs.carrierMid = regWdata;
        sbc_pkg::ADDR_CARRIER_LOW: begin
          state_d.regs.carrierLow = regWdata;
          state_d.pend = 1'b1;
        end
        sbc_pkg::ADDR_OSC_CTRL: state_d.regs.pllBandwidth = regWdata[1:0];
        sbc_pkg::ADDR_SUPPLY_MON: state_d.regs.supply = regWdata;
        sbc_pkg::ADDR_ROUTING: state_d.regs.routing = regWdata;
        sbc_pkg::ADDR_ROUTING_TWO: state_d.regs.routingTwo = regWdata;
        sbc_pkg::ADDR_EXT_REF: state_d.regs.extRef = regWdata;
        default: state_d.regs = state_q.regs;
      endcase
    end
    if (state_q.pend) begin
      state_d.carrier = {state_q.regs.carrierHigh, state_q.regs.carrierMid,
        state_q.regs.carrierLow};
    end
    case (state_q.trim)
      sbc_pkg::TRIM_IDLE: begin
        if (regWrite && regAddr == sbc_pkg::ADDR_OSC_CTRL
            && regWdata[sbc_pkg::OSC_REQUEST_BIT]) begin
          state_d.trim = sbc_pkg::TRIM_RUN;
          state_d.trimCount = '0;
          state_d.trimDone = 1'b0;
        end
      end
      sbc_pkg::TRIM_RUN: begin
        // a request while running is absorbed by the run in progress
        if (state_q.trimCount == sbc_pkg::RC_TRIM_CYCLES - 10'h001) begin
          state_d.trim = sbc_pkg::TRIM_IDLE;
          state_d.trimDone = 1'b1;
        end else begin
          state_d.trimCount = state_q.trimCount + 10'h001;
        end
      end
      default: state_d.trim = sbc_pkg::TRIM_IDLE;
    endcase
    state_d.clkDiv = state_q.clkDiv + 6'h01;
    if (contRaw) begin
      state_d.curBit = txSerialDataPin;
    end else if (divTick && bufOutValid) begin
      state_d.curBit = bufOutData;
    end
    state_d.bitClk = contGauss && divTick;
    state_d.paOn = txOn && (!state_q.regs.mode[sbc_pkg::MODE_OOK_BIT] || state_q.curBit);
    synthWord = state_q.carrier;
    if (txOn && !state_q.regs.mode[sbc_pkg::MODE_OOK_BIT]) begin
      synthWord = state_q.curBit ? state_q.carrier + {10'h000, devWord}
        : state_q.carrier - {10'h000, devWord};
    end
    state_d.synth.intPart = synthWord[23:sbc_pkg::FRAC_STEP_BITS];
    state_d.synth.fracPart = synthWord[sbc_pkg::FRAC_STEP_BITS-1:0];
    state_d.synth.enable = xtalStable && !sleep;
    state_d.synth.lowNoisePll = state_q.regs.mode[sbc_pkg::MODE_LOW_NOISE_BIT]
      && !state_q.regs.mode[sbc_pkg::MODE_RX_BIT];
    state_d.synth.bandwidth = state_q.regs.pllBandwidth;
    state_d.pinOut = 6'h00;
    state_d.pinOe = 6'h00;
    state_d.pinOut[1] = state_q.bitClk;
    state_d.pinOe[1] = contGauss;
    if (!sleep && clkField <= sbc_pkg::CLK_OUT_MAX) begin
      state_d.pinOut[5] = state_q.clkDiv[clkField];
      state_d.pinOe[5] = 1'b1;
    end
    state_d.pinOut = (state_d.pinOut & ~batSel) | (batSel & {6{lowBatLevel}});
    state_d.pinOe = state_d.pinOe | batSel;
    state_d.pinOe[2] = 1'b0;
    if (regRead) begin
      case (regAddr)
        sbc_pkg::ADDR_MODE: state_d.rdata = state_q.regs.mode;
        sbc_pkg::ADDR_RATE_HIGH: state_d.rdata = state_q.regs.rateHigh;
        sbc_pkg::ADDR_RATE_LOW: state_d.rdata = state_q.regs.rateLow;
        sbc_pkg::ADDR_RATE_FRAC: state_d.rdata = {4'h0, state_q.regs.rateFrac};
        sbc_pkg::ADDR_DEV_HIGH: state_d.rdata = {2'h0, state_q.regs.devHigh};
        sbc_pkg::ADDR_DEV_LOW: state_d.rdata = state_q.regs.devLow;
        sbc_pkg::ADDR_CARRIER_HIGH: state_d.rdata = state_q.regs.carrierHigh;
        sbc_pkg::ADDR_CARRIER_MID: state_d.rdata = state_q.regs.carrierMid;
        sbc_pkg::ADDR_CARRIER_LOW: state_d.rdata = state_q.regs.carrierLow;
        sbc_pkg::ADDR_OSC_CTRL: state_d.rdata = {4'h0, state_q.trim == sbc_pkg::TRIM_RUN,
          state_q.trimDone, state_q.regs.pllBandwidth};
        sbc_pkg::ADDR_SUPPLY_MON: state_d.rdata = state_q.regs.supply;
        sbc_pkg::ADDR_ROUTING: state_d.rdata = state_q.regs.routing;
        sbc_pkg::ADDR_ROUTING_TWO: state_d.rdata = state_q.regs.routingTwo;
        sbc_pkg::ADDR_EXT_REF: state_d.rdata = state_q.regs.extRef;
        default: state_d.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_q <= STATE_RST;
    end else if (clkEn) begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign regRdata = state_q.rdata;
  assign generalPinOut = state_q.pinOut;
  assign generalPinOe = state_q.pinOe;
  assign synthConfig = state_q.synth;
  assign txPaOn = state_q.paOn;
  assign rcTrimActive = (state_q.trim == sbc_pkg::TRIM_RUN);
  assign extRefSelect = state_q.regs.extRef[sbc_pkg::EXT_REF_BIT];
  assign supplyThreshold = state_q.regs.supply[2:0];

  // ----------------------------------------
  // checks
  // ----------------------------------------
  carrier_apply_a: assert property (@(posedge clk_sys) disable iff (reset)
    state_q.pend && clkEn |=> state_q.carrier == $past({state_q.regs.carrierHigh,
      state_q.regs.carrierMid, state_q.regs.carrierLow}))
    else $error("staged carrier not applied");
  carrier_hold_a: assert property (@(posedge clk_sys) disable iff (reset)
    !state_q.pend |=> $stable(state_q.carrier))
    else $error("carrier changed without low byte write");
  frac_ook_a: assert property (@(posedge clk_sys) disable iff (reset)
    state_q.regs.mode[sbc_pkg::MODE_OOK_BIT] && rawPeriod[19:4] >= 16'h0002
    |-> period16[3:0] == 4'h0)
    else $error("fraction used in on-off keying");
  bit_clock_pulse_a: assert property (@(posedge clk_sys) disable iff (reset)
    state_q.bitClk |=> !state_q.bitClk)
    else $error("bit clock longer than one cycle");
  trim_done_a: assert property (@(posedge clk_sys) disable iff (reset)
    clkEn && state_q.trim == sbc_pkg::TRIM_RUN
    && state_q.trimCount == sbc_pkg::RC_TRIM_CYCLES - 10'h001
    |=> state_q.trimDone && !rcTrimActive)
    else $error("trim done not set");
  powerup_trim_a: assert property (@(posedge clk_sys)
    $fell(reset) |-> rcTrimActive && state_q.trimCount == 10'h000)
    else $error("power-up trim not started");
  synth_start_a: assert property (@(posedge clk_sys) disable iff (reset)
    clkEn && xtalStable && !sleep |=> synthConfig.enable)
    else $error("synthesizer not started");
  rx_pll_a: assert property (@(posedge clk_sys) disable iff (reset)
    clkEn && state_q.regs.mode[sbc_pkg::MODE_RX_BIT] |=> !synthConfig.lowNoisePll)
    else $error("low-noise synthesizer in receive");
  lowbat_route_a: assert property (@(posedge clk_sys) disable iff (reset)
    clkEn && state_q.regs.routing[2:0] < sbc_pkg::PIN_COUNT
    |=> generalPinOut[$past(state_q.regs.routing[2:0])] == $past(lowBatLevel))
    else $error("low battery not on routed pin");
  sleep_clock_a: assert property (@(posedge clk_sys) disable iff (reset)
    clkEn && sleep && state_q.regs.routing[2:0] != 3'h5 |=> !generalPinOe[5])
    else $error("clock out active in sleep");
  deviation_a: assert property (@(posedge clk_sys) disable iff (reset)
    clkEn && txOn && !state_q.regs.mode[sbc_pkg::MODE_OOK_BIT] && state_q.curBit
    |=> {synthConfig.intPart, synthConfig.fracPart}
      == $past(state_q.carrier + {10'h000, devWord}))
    else $error("deviation not applied");
  trim_cover_c: cover property (@(posedge clk_sys) $rose(state_q.trimDone));
  bit_clock_cover_c: cover property (@(posedge clk_sys) state_q.bitClk);
  carrier_cover_c: cover property (@(posedge clk_sys) state_q.pend ##1 $changed(state_q.carrier));
  backpressure_cover_c: cover property (@(posedge clk_sys) packetTx && txBitValid && !txBitReady);
endmodule : sbc_synth_control
`default_nettype wire

/* hdl/sbc_pkg.sv */
/*
  constants, register layout and carrier types of the synthesizer and bit-rate control.
  assumes a single 100 MHz system clock and a byte-wide register port.
*/
package sbc_pkg;
  // ----------------------------------------
  // register addresses
  // ----------------------------------------
  localparam logic [6:0] ADDR_MODE = 7'h01;
  localparam logic [6:0] ADDR_RATE_HIGH = 7'h02;
  localparam logic [6:0] ADDR_RATE_LOW = 7'h03;
  localparam logic [6:0] ADDR_DEV_HIGH = 7'h04;
  localparam logic [6:0] ADDR_DEV_LOW = 7'h05;
  localparam logic [6:0] ADDR_CARRIER_HIGH = 7'h06;
  localparam logic [6:0] ADDR_CARRIER_MID = 7'h07;
  localparam logic [6:0] ADDR_CARRIER_LOW = 7'h08;
  localparam logic [6:0] ADDR_OSC_CTRL = 7'h0a;
  localparam logic [6:0] ADDR_SUPPLY_MON = 7'h3c;
  localparam logic [6:0] ADDR_ROUTING = 7'h40;
  localparam logic [6:0] ADDR_ROUTING_TWO = 7'h41;
  localparam logic [6:0] ADDR_EXT_REF = 7'h4b;
  localparam logic [6:0] ADDR_RATE_FRAC = 7'h5d;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int MODE_CONT_BIT = 0;
  localparam int MODE_OOK_BIT = 1;
  localparam int MODE_GAUSS_BIT = 2;
  localparam int MODE_TX_BIT = 3;
  localparam int MODE_RX_BIT = 4;
  localparam int MODE_SLEEP_BIT = 5;
  localparam int MODE_LOW_NOISE_BIT = 6;
  localparam int OSC_REQUEST_BIT = 3;
  localparam int OSC_DONE_BIT = 2;
  localparam int SUPPLY_ENABLE_BIT = 3;
  localparam int EXT_REF_BIT = 4;
  localparam int FRAC_STEP_BITS = 19;
  localparam logic [2:0] CLK_OUT_OFF = 3'h7;
  localparam logic [2:0] CLK_OUT_MAX = 3'h5;
  localparam logic [2:0] PIN_COUNT = 3'h6;
  localparam logic [20:0] ONE_CYCLE16 = 21'h01_0010;
  localparam logic [19:0] MIN_PERIOD16 = 20'h0_0020;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] RATE_HIGH_RST = 8'h1a;
  localparam logic [7:0] RATE_LOW_RST = 8'h0b;
  localparam logic [3:0] RATE_FRAC_RST = 4'h0;
  localparam logic [5:0] DEV_HIGH_RST = 6'h00;
  localparam logic [7:0] DEV_LOW_RST = 8'h52;
  localparam logic [7:0] CARRIER_HIGH_RST = 8'he4;
  localparam logic [7:0] CARRIER_MID_RST = 8'hc0;
  localparam logic [7:0] CARRIER_LOW_RST = 8'h00;
  localparam logic [1:0] PLL_BW_RST = 2'h3;
  localparam logic [7:0] SUPPLY_RST = 8'h02;
  localparam logic [7:0] ROUTING_RST = 8'h07;
  localparam logic [7:0] ROUTING_TWO_RST = 8'h00;
  localparam logic [7:0] EXT_REF_RST = 8'h00;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int RC_TRIM_TIME_NS = 5000;
  localparam logic [9:0] RC_TRIM_CYCLES =
    10'((RC_TRIM_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {
    TRIM_IDLE = 2'b00,
    TRIM_RUN = 2'b01
  } sbc_trim_state_type;

  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] rateHigh;
    logic [7:0] rateLow;
    logic [3:0] rateFrac;
    logic [5:0] devHigh;
    logic [7:0] devLow;
    logic [7:0] carrierHigh;
    logic [7:0] carrierMid;
    logic [7:0] carrierLow;
    logic [1:0] pllBandwidth;
    logic [7:0] supply;
    logic [7:0] routing;
    logic [7:0] routingTwo;
    logic [7:0] extRef;
  } sbc_regs_type;

  localparam sbc_regs_type REGS_RST = '{MODE_RST, RATE_HIGH_RST, RATE_LOW_RST,
    RATE_FRAC_RST, DEV_HIGH_RST, DEV_LOW_RST, CARRIER_HIGH_RST, CARRIER_MID_RST,
    CARRIER_LOW_RST, PLL_BW_RST, SUPPLY_RST, ROUTING_RST, ROUTING_TWO_RST, EXT_REF_RST};

  typedef struct packed {
    logic enable;
    logic lowNoisePll;
    logic [1:0] bandwidth;
    logic [4:0] intPart;
    logic [18:0] fracPart;
  } sbc_synth_type;

  localparam sbc_synth_type SYNTH_RST = '{1'b0, 1'b0, 2'h0, 5'h00, 19'h0_0000};

  // one-hot pin select, all zero for an index past the last pin
  function automatic logic [5:0] sbc_pin_select(input logic [2:0] index);
    logic [5:0] sel;
    sel = 6'h00;
    if (index < PIN_COUNT) begin
      sel[index] = 1'b1;
    end
    return sel;
  endfunction : sbc_pin_select
endpackage : sbc_pkg

/* hdl/sbc_bit_buffer.sv */
/*
  two-entry buffer for transmit bits with valid and ready on both sides.
  assumes the drain side may stall for any number of cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module sbc_bit_buffer #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 2
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clkEn,
  input wire logic inValid,
  input wire logic [WIDTH-1:0] inData,
  output logic inReady,
  output logic outValid,
  output logic [WIDTH-1:0] outData,
  input wire logic outReady
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0] FULL_COUNT = (PW + 1)'(DEPTH);
  localparam logic [PW-1:0] LAST_SLOT = PW'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wrPtr;
    logic [PW-1:0] rdPtr;
    logic [PW:0] count;
  } sbc_buf_state_type;

  sbc_buf_state_type state_q;
  sbc_buf_state_type state_d;
  logic push;
  logic pop;

  assign inReady = (state_q.count != FULL_COUNT);
  assign outValid = (state_q.count != '0);
  assign outData = state_q.mem[state_q.rdPtr];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  // ----------------------------------------
  // pointers and storage
  // ----------------------------------------
  always_comb begin
    state_d = state_q;
    if (push) begin
      state_d.mem[state_q.wrPtr] = inData;
      state_d.wrPtr = (state_q.wrPtr == LAST_SLOT) ? '0 : state_q.wrPtr + 1'b1;
    end
    if (pop) begin
      state_d.rdPtr = (state_q.rdPtr == LAST_SLOT) ? '0 : state_q.rdPtr + 1'b1;
    end
    if (push && !pop) begin
      state_d.count = state_q.count + 1'b1;
    end else if (pop && !push) begin
      state_d.count = state_q.count - 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_q <= '0;
    end else if (clkEn) begin
      state_q <= state_d;
    end
  end
endmodule : sbc_bit_buffer
`default_nettype wire

/* hdl/sbc_rate_divider.sv */
/*
  fractional bit-rate divider in sixteenths of a reference cycle.
  assumes the period word is never below two whole cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module sbc_rate_divider (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clkEn,
  input wire logic run,
  input wire logic [19:0] period16,
  output logic tick
);
  typedef struct packed {
    logic [19:0] acc;
    logic tick;
  } sbc_div_state_type;

  sbc_div_state_type state_q;
  sbc_div_state_type state_d;
  logic [20:0] next;

  assign tick = state_q.tick;

  // ----------------------------------------
  // accumulator
  // ----------------------------------------
  always_comb begin
    state_d = state_q;
    next = {1'b0, state_q.acc} + sbc_pkg::ONE_CYCLE16 - 21'h01_0000;
    state_d.tick = 1'b0;
    if (!run) begin
      state_d.acc = '0;
    end else if (next >= {1'b0, period16}) begin
      // remainder carries so the average rate holds the fraction
      state_d.acc = 20'(next - {1'b0, period16});
      // a shortened period must not leave a second tick due
      if (state_d.acc >= 20'h0_0010) begin
        state_d.acc = '0;
      end
      state_d.tick = 1'b1;
    end else begin
      state_d.acc = next[19:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_q <= '0;
    end else if (clkEn) begin
      state_q <= state_d;
    end
  end
endmodule : sbc_rate_divider
`default_nettype wire

/* verif/sbc_host_model.sv */
/*
  host side: transmit bit source with random stalls, data pin stepped by the bit clock.
  assumes the bench seeds the random generator and reads sentCount.
*/
`timescale 1ns/1ps
`default_nettype none
module sbc_host_model (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic txBitReady,
  input wire logic bitClockPin,
  output logic txBitValid,
  output logic txBitData,
  output logic txSerialDataPin,
  output int sentCount
);
  // ----------
  // bit source
  // ----------
  always @(posedge clk_sys) begin
    automatic logic took = txBitValid && txBitReady;
    #1;
    if (reset) begin
      txBitValid = 1'b0;
      txBitData = 1'b0;
      txSerialDataPin = 1'b0;
      sentCount = 0;
    end else if (took || !txBitValid) begin
      sentCount = sentCount + int'(took);
      // a quarter of the cycles stall, so the buffer also sees gaps
      txBitValid = ($urandom_range(3) != 0);
      txBitData = 1'($urandom_range(1));
    end
    if (bitClockPin) begin
      txSerialDataPin = 1'($urandom_range(1));
    end
  end
endmodule : sbc_host_model
`default_nettype wire

/* verif/synth_bitrate_control_tb.sv */
/*
  bench: registers, carrier staging, bit timing, trim, clock out, pin routing.
  assumes sbc_host_model feeds the transmit stream and data pin.
*/
`timescale 1ns/1ps
`default_nettype none
module synth_bitrate_control_tb;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic xtalStable = 1'b0;
  logic lowBat = 1'b0;
  logic [6:0] regAddr = 7'h00;
  logic [7:0] regWdata = 8'h00;
  logic [7:0] regRdata;
  logic txBitValid, txBitData, txBitReady, txPin, rcTrimActive, extRefSelect, paOn;
  logic [5:0] pinOut, pinOe;
  logic [2:0] supplyThreshold;
  sbc_pkg::sbc_synth_type synth;
  int failures = 0;
  int comparisons = 0;
  int sent;
  always #5 clk_sys = ~clk_sys;
  sbc_synth_control dut_u (.clk_sys(clk_sys), .reset(reset), .clkEn(1'b1), .regAddr(regAddr),
    .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata),
    .txBitValid(txBitValid), .txBitData(txBitData), .txBitReady(txBitReady),
    .txSerialDataPin(txPin), .xtalStable(xtalStable), .lowBatteryCross(lowBat),
    .generalPinOut(pinOut), .generalPinOe(pinOe), .synthConfig(synth), .txPaOn(paOn),
    .rcTrimActive(rcTrimActive), .extRefSelect(extRefSelect), .supplyThreshold(supplyThreshold));
  sbc_host_model host_u (.clk_sys(clk_sys), .reset(reset), .txBitReady(txBitReady),
    .bitClockPin(pinOut[1]), .txBitValid(txBitValid), .txBitData(txBitData),
    .txSerialDataPin(txPin), .sentCount(sent));
  // ----------
  // helpers
  // ----------
  task automatic summarize();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize
  task automatic chk(string name, logic [23:0] exp, logic [23:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic near(string name, int exp, int got);
    comparisons++;
    if (got < exp - 2 || got > exp + 2) begin
      failures++;
      $display("unexpected %s: expected %0d seen %0d", name, exp, got);
    end
  endtask : near
  task automatic cyc(int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : cyc
  task automatic wr(logic [6:0] a, logic [7:0] d);
    regAddr = a;
    regWdata = d;
    regWrite = 1'b1;
    cyc(1);
    regWrite = 1'b0;
    cyc(1);
  endtask : wr
  task automatic rd(logic [6:0] a, output logic [7:0] d);
    regAddr = a;
    regRead = 1'b1;
    cyc(1);
    regRead = 1'b0;
    cyc(1);
    d = regRdata;
  endtask : rd
  task automatic trimWait(output int n);
    for (n = 0; n < 700 && rcTrimActive !== 1'b0; n++) cyc(1);
    if (n == 700) begin
      failures++;
      summarize();
    end
  endtask : trimWait
  task automatic rises(int p, int n, output int c);
    logic prev;
    c = 0;
    prev = pinOut[p];
    repeat (n) begin
      cyc(1);
      if (pinOut[p] === 1'b1 && prev === 1'b0) c++;
      prev = pinOut[p];
    end
  endtask : rises
  // on-off keying drops the fraction
  function automatic int pulses(int n, int word, int frac, bit ook);
    return n * 16 / (word * 16 + (ook ? 0 : frac));
  endfunction : pulses
  // ----------
  // tests
  // ----------
  initial begin
    logic [7:0] d;
    logic [23:0] w, old;
    int n, c, m, word;
    static logic [7:0] modes [3] = '{8'h0d, 8'h0f, 8'h0d};
    static int fracs [3] = '{8, 8, 0};
    void'($urandom(32'h8e15_390f));
    cyc(16);
    reset = 1'b0;
    chk("power-up trim", 1, rcTrimActive);
    w = {sbc_pkg::CARRIER_HIGH_RST, sbc_pkg::CARRIER_MID_RST, sbc_pkg::CARRIER_LOW_RST};
    for (n = 0; n < 3; n++) begin
      rd(sbc_pkg::ADDR_CARRIER_HIGH + 7'(n), d);
      chk("carrier reset", w[23 - 8 * n -: 8], d);
    end
    trimWait(n);
    rd(sbc_pkg::ADDR_OSC_CTRL, d);
    chk("power-up trim done", 1, d[2]);
    chk("synth before xtal", 0, synth.enable);
    xtalStable = 1'b1;
    cyc(4);
    chk("synth after xtal", 1, synth.enable);
    $display("test reset done");
    for (n = 0; n < 4; n++) begin
      w = (n == 0) ? 24'hff_ffff : 24'($urandom);
      old = {synth.intPart, synth.fracPart};
      wr(sbc_pkg::ADDR_CARRIER_HIGH, w[23:16]);
      wr(sbc_pkg::ADDR_CARRIER_MID, w[15:8]);
      chk("carrier held", old, {synth.intPart, synth.fracPart});
      wr(sbc_pkg::ADDR_CARRIER_LOW, w[7:0]);
      chk("carrier staged", old, {synth.intPart, synth.fracPart});
      cyc(2);
      chk("carrier applied", w, {synth.intPart, synth.fracPart});
    end
    old = w;
    $display("test carrier done");
    m = sent;
    for (n = 0; n < 3; n++) begin
      word = $urandom_range(6, 3);
      wr(sbc_pkg::ADDR_RATE_HIGH, 8'h00);
      wr(sbc_pkg::ADDR_RATE_LOW, 8'(word));
      wr(sbc_pkg::ADDR_RATE_FRAC, 8'(fracs[n]));
      wr(sbc_pkg::ADDR_MODE, modes[n]);
      rises(1, 720, c);
      near("bit clock pulses", pulses(720, word, fracs[n], modes[n][1]), c);
    end
    chk("taken outside packet", 24'(m), 24'(sent));
    $display("test bit clock done");
    w = 24'($urandom_range(1000, 10));
    wr(sbc_pkg::ADDR_DEV_HIGH, 8'(w[13:8]));
    wr(sbc_pkg::ADDR_DEV_LOW, w[7:0]);
    wr(sbc_pkg::ADDR_RATE_LOW, 8'h04);
    wr(sbc_pkg::ADDR_MODE, 8'h08);
    cyc(4);
    m = sent;
    c = 0;
    for (n = 0; n < 400; n++) begin
      cyc(1);
      if ({synth.intPart, synth.fracPart} !== old + w &&
          {synth.intPart, synth.fracPart} !== old - w) c++;
    end
    chk("fsk word off grid", 0, 24'(c));
    near("bits taken", pulses(400, 4, 0, 1'b0) + 1, sent - m);
    chk("pa on", 1, paOn);
    wr(sbc_pkg::ADDR_MODE, 8'h09);
    cyc(2);
    chk("raw data", txPin ? old + w : old - w, {synth.intPart, synth.fracPart});
    wr(sbc_pkg::ADDR_MODE, 8'h50);
    chk("rx pll", 0, synth.lowNoisePll);
    $display("test packet done");
    for (n = 0; n < 3; n++) begin
      if (n > 0) wr(sbc_pkg::ADDR_ROUTING_TWO, 8'(2 * n));
      rises(5, 64, c);
      near("clock out rises", 64 >> (2 * n + 1), c);
    end
    wr(sbc_pkg::ADDR_SUPPLY_MON, 8'h0d);
    chk("threshold", 5, supplyThreshold);
    wr(sbc_pkg::ADDR_ROUTING, 8'h03);
    lowBat = 1'b1;
    cyc(3);
    chk("battery pin", 2'b11, {pinOut[3], pinOe[3]});
    wr(sbc_pkg::ADDR_EXT_REF, 8'h10);
    chk("ext ref", 1, extRefSelect);
    $display("test pins done");
    wr(sbc_pkg::ADDR_OSC_CTRL, 8'h08);
    chk("trim busy", 1, rcTrimActive);
    rd(sbc_pkg::ADDR_OSC_CTRL, d);
    chk("trim early", 2'b10, d[3:2]);
    trimWait(n);
    near("trim cycles", 498, n);
    rd(sbc_pkg::ADDR_OSC_CTRL, d);
    chk("trim done", 2'b01, d[3:2]);
    wr(sbc_pkg::ADDR_MODE, 8'h20);
    rises(5, 64, c);
    near("clock out in sleep", 0, c);
    $display("test trim and sleep done");
    summarize();
  end
endmodule : synth_bitrate_control_tb
`default_nettype wire
